// [hw/ofm_sel_mem.sv]
// Small memory of pending assignment codes with registered read data.
`timescale 1ns/100ps
module ofm_sel_mem (
  // Clock, reset and enable.
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Access port.
  ofm_sel_if.mem bus
);
  // Pending codes survive reset like stored parameters, so a new code reaches the next power-up.
  logic [7:0] mem [0:ofm_pkg::NUM_OUT-1] = '{0: ofm_pkg::DEF_OUT1, 1: ofm_pkg::DEF_OUT2,
    2: ofm_pkg::DEF_OUT3, default: ofm_pkg::DEF_OTHER};

  always_ff @(posedge mclk) begin
    if (ce && bus.we && bus.waddr < 5'(ofm_pkg::NUM_OUT)) begin
      mem[bus.waddr] <= bus.wdata;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus.rdata <= 8'h00;
    end else if (ce) begin
      bus.rdata <= (bus.raddr < 5'(ofm_pkg::NUM_OUT)) ? mem[bus.raddr] : 8'h00;
    end
  end
endmodule

// [hw/ofm_top.sv]
// Output terminal function mux with status generation and APB registers.
//
// Function
// - Each output carries one status function chosen by a one-to-one code.
// - Outputs 1-5 are physical pins; outputs 6-21 are communication data only.
// - New assignment codes take effect only at the next power-up.
// - Ready needs servo-on, forced-stop on, coast off, no alarm, control ready.
// - In-position asserts once positioning motion has finished.
// - Position control: in-position is on with done, overtravel or clear, and off upon alarm.
// - Speed or torque control holds in-position permanently on.
// - In-position format 0 gives a level, 1 gives a single-shot pulse.
// - Speed limit detect uses position/speed max speed except pulse operation in position control.
// - Torque mode uses torque max speed, or multistep selection when selected.
// - Overwrite completion asserts after teaching write, holds while entering.
// - Brake output drops whenever servo-on turns off.
// - Ready drops after brake hold torque time elapses, or at once on alarm.
// - Alarm detect: open variant on, closed variant off, on alarm.
`timescale 1ns/100ps
module ofm_top (
  // Clock, reset and enable.
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Drive status inputs.
  input wire logic servo_on_input,
  input wire logic forced_stop_input,
  input wire logic coast_input,
  input wire logic alarm_detected,
  input wire logic servo_ctrl_ready,
  input wire logic overtravel,
  input wire logic dev_clear,
  input wire logic positioning_done,
  input wire logic pulse_operation,
  input wire logic [2:0] control_mode,
  input wire logic [15:0] motor_speed,
  input wire logic multistep_speed_sel_0,
  input wire logic multistep_speed_sel_1,
  input wire logic multistep_speed_sel_2,
  input wire logic teach_written,
  input wire logic teach_entering,
  // Outputs.
  output logic [4:0] general_output,
  output logic [15:0] comm_output,
  output logic brake_release,
  output logic irq
);
  ofm_sel_if sel ();
  ofm_sel_mem u_mem (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .bus(sel.mem)
  );

  ////////////////////////////////////////////////////////////////////////
  // Registers.
  logic [7:0] active_code [0:ofm_pkg::NUM_OUT-1];
  logic [4:0] load_idx;
  logic loading;
  logic [1:0] ctrl;
  logic [15:0] max_speed_pos_speed_param;
  logic [15:0] max_speed_torque_param;
  logic [15:0] brake_hold_torque_time;
  logic [15:0] step_speed [0:7];
  logic [3:0] irq_status;
  logic [3:0] irq_mask;
  logic [20:0] func_out;
  logic rd_pending;
  logic rd_sel;
  logic [31:0] rd_hold;

  logic apb_acc;
  logic apb_wr;
  logic [4:0] sel_idx;
  assign apb_acc = psel && penable;
  assign apb_wr = apb_acc && pwrite;
  assign sel_idx = 5'(paddr[11:2]);

  function automatic logic in_range(input logic [11:0] a, input logic [11:0] lo,
                                    input logic [11:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Power-up latch of the assignment table from the pending memory.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      loading <= 1'b1;
      load_idx <= 5'h00;
    end else if (ce && loading) begin
      if (load_idx == 5'(ofm_pkg::NUM_OUT)) begin
        loading <= 1'b0;
      end else begin
        load_idx <= load_idx + 5'h01;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < ofm_pkg::NUM_OUT; i++) begin
        active_code[i] <= ofm_pkg::FN_NONE;
      end
    end else if (ce && loading && load_idx != 5'h00) begin
      active_code[load_idx - 5'h01] <= sel.rdata;
    end
  end

  // Memory port: the loader reads first, then software reads.
  assign sel.we = apb_wr && !loading && in_range(paddr, ofm_pkg::A_SEL_BASE,
                  ofm_pkg::A_SEL_LAST);
  assign sel.waddr = sel_idx;
  assign sel.wdata = pwdata[7:0];
  assign sel.raddr = loading ? load_idx : sel_idx;

  ////////////////////////////////////////////////////////////////////////
  // APB register writes.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl <= 2'b00;
      max_speed_pos_speed_param <= ofm_pkg::DEF_SPEED;
      max_speed_torque_param <= ofm_pkg::DEF_SPEED;
      brake_hold_torque_time <= ofm_pkg::DEF_HOLD_MS;
      irq_mask <= 4'h0;
      for (int i = 0; i < 8; i++) begin
        step_speed[i] <= ofm_pkg::DEF_SPEED;
      end
    end else if (ce && apb_wr && pready) begin
      if (paddr == ofm_pkg::A_CTRL) begin
        ctrl <= pwdata[1:0];
      end else if (paddr == ofm_pkg::A_MAXPS) begin
        max_speed_pos_speed_param <= pwdata[15:0];
      end else if (paddr == ofm_pkg::A_MAXTQ) begin
        max_speed_torque_param <= pwdata[15:0];
      end else if (paddr == ofm_pkg::A_HOLD) begin
        brake_hold_torque_time <= pwdata[15:0];
      end else if (paddr == ofm_pkg::A_IRQ_MASK) begin
        irq_mask <= pwdata[3:0];
      end else if (in_range(paddr, ofm_pkg::A_STEP0, ofm_pkg::A_STEP7)) begin
        step_speed[paddr[4:2]] <= pwdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB read path: selection reads take one wait state for the memory.
  logic is_sel;
  logic mapped;
  logic [31:0] rd_mux;
  assign is_sel = in_range(paddr, ofm_pkg::A_SEL_BASE, ofm_pkg::A_SEL_LAST)
                  && paddr[1:0] == 2'b00;
  assign mapped = is_sel || paddr == ofm_pkg::A_CTRL || paddr == ofm_pkg::A_MAXPS
                  || paddr == ofm_pkg::A_MAXTQ || paddr == ofm_pkg::A_HOLD
                  || paddr == ofm_pkg::A_OUTS || paddr == ofm_pkg::A_IRQ_ST
                  || paddr == ofm_pkg::A_IRQ_MASK
                  || (in_range(paddr, ofm_pkg::A_STEP0, ofm_pkg::A_STEP7)
                      && paddr[1:0] == 2'b00);
  assign pready = !(is_sel && !pwrite) || rd_pending;
  assign pslverr = apb_acc && !mapped;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (paddr == ofm_pkg::A_CTRL) begin
      rd_mux = {30'h0, ctrl};
    end else if (paddr == ofm_pkg::A_MAXPS) begin
      rd_mux = {16'h0, max_speed_pos_speed_param};
    end else if (paddr == ofm_pkg::A_MAXTQ) begin
      rd_mux = {16'h0, max_speed_torque_param};
    end else if (paddr == ofm_pkg::A_HOLD) begin
      rd_mux = {16'h0, brake_hold_torque_time};
    end else if (paddr == ofm_pkg::A_OUTS) begin
      rd_mux = {11'h0, func_out};
    end else if (paddr == ofm_pkg::A_IRQ_ST) begin
      rd_mux = {28'h0, irq_status};
    end else if (paddr == ofm_pkg::A_IRQ_MASK) begin
      rd_mux = {28'h0, irq_mask};
    end else if (in_range(paddr, ofm_pkg::A_STEP0, ofm_pkg::A_STEP7)) begin
      rd_mux = {16'h0, step_speed[paddr[4:2]]};
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_pending <= 1'b0;
      rd_sel <= 1'b0;
    end else if (ce) begin
      rd_pending <= apb_acc && is_sel && !pwrite && !rd_pending && !loading;
      rd_sel <= is_sel;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_hold <= 32'h0000_0000;
    end else if (ce && psel && !penable) begin
      rd_hold <= rd_mux;
    end
  end
  assign prdata = rd_sel ? {24'h0, sel.rdata} : rd_hold;

  ////////////////////////////////////////////////////////////////////////
  // Status functions.
  logic alarm_closed;
  logic ready_cond;
  logic ready_out;
  logic inpos_level;
  logic inpos_prev;
  logic inpos_out;
  logic [15:0] pulse_cnt;
  logic [15:0] speed_limit;
  logic spd_lim;
  logic ovwr;
  logic [2:0] step;

  assign ready_cond = servo_on_input && forced_stop_input && !coast_input
                      && !alarm_detected && servo_ctrl_ready;
  assign alarm_closed = !alarm_detected;

  // Position mode keeps in-position on through S-ON, OT, clear and stop.
  always_comb begin
    if (control_mode != ofm_pkg::OFM_MODE_POS) begin
      inpos_level = 1'b1;
    end else if (alarm_detected) begin
      inpos_level = 1'b0;
    end else begin
      inpos_level = positioning_done || overtravel || dev_clear;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      inpos_prev <= 1'b0;
      pulse_cnt <= 16'h0000;
    end else if (ce) begin
      inpos_prev <= inpos_level;
      if (inpos_level && !inpos_prev) begin
        pulse_cnt <= 16'(ofm_pkg::PULSE_CYC);
      end else if (pulse_cnt != 16'h0000) begin
        pulse_cnt <= pulse_cnt - 16'h0001;
      end
    end
  end
  assign inpos_out = ctrl[ofm_pkg::CTRL_INPOS_FMT] ? (pulse_cnt != 16'h0000)
                     : inpos_level;

  assign step = {multistep_speed_sel_2, multistep_speed_sel_1, multistep_speed_sel_0};
  always_comb begin
    if (control_mode == ofm_pkg::OFM_MODE_TRQ) begin
      speed_limit = ctrl[ofm_pkg::CTRL_TQ_SEL] ? step_speed[step]
                    : max_speed_torque_param;
    end else begin
      speed_limit = max_speed_pos_speed_param;
    end
  end
  assign spd_lim = !(pulse_operation && control_mode == ofm_pkg::OFM_MODE_POS)
                   && motor_speed >= speed_limit;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ovwr <= 1'b0;
    end else if (ce) begin
      if (teach_written) begin
        ovwr <= 1'b1;
      end else if (!teach_entering) begin
        ovwr <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Brake sequencing with hold time before ready drops.
  ofm_pkg::ofm_brake_e bstate;
  logic [16:0] tick;
  logic [15:0] ms_cnt;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bstate <= ofm_pkg::OFM_ST_IDLE;
      tick <= 17'h00000;
      ms_cnt <= 16'h0000;
    end else if (ce) begin
      case (bstate)
        ofm_pkg::OFM_ST_IDLE: begin
          if (ready_cond) begin
            bstate <= ofm_pkg::OFM_ST_RUN;
          end
        end
        ofm_pkg::OFM_ST_RUN: begin
          if (!ready_cond) begin
            bstate <= ofm_pkg::OFM_ST_HOLD;
            tick <= 17'h00000;
            ms_cnt <= 16'h0000;
          end
        end
        ofm_pkg::OFM_ST_HOLD: begin
          if (alarm_detected || ms_cnt >= brake_hold_torque_time) begin
            bstate <= ofm_pkg::OFM_ST_OFF;
          end else if (tick == 17'(ofm_pkg::MS_CYC - 1)) begin
            tick <= 17'h00000;
            ms_cnt <= ms_cnt + 16'h0001;
          end else begin
            tick <= tick + 17'h00001;
          end
        end
        default: begin
          bstate <= ofm_pkg::OFM_ST_IDLE;
        end
      endcase
    end
  end
  assign ready_out = bstate == ofm_pkg::OFM_ST_RUN
                     || (bstate == ofm_pkg::OFM_ST_HOLD && !alarm_detected);
  assign brake_release = bstate == ofm_pkg::OFM_ST_RUN && servo_on_input;

  ////////////////////////////////////////////////////////////////////////
  // Code to function mapping.
  function automatic logic pick(input logic [7:0] code, input logic [8:0] f);
    if (code == ofm_pkg::FN_RDY) begin
      return f[0];
    end else if (code == ofm_pkg::FN_INPOS) begin
      return f[1];
    end else if (code == ofm_pkg::FN_SPDLIM) begin
      return f[2];
    end else if (code == ofm_pkg::FN_OVWR) begin
      return f[3];
    end else if (code == ofm_pkg::FN_BRAKE) begin
      return f[4];
    end else if (code == ofm_pkg::FN_ALM_NO) begin
      return f[5];
    end else if (code == ofm_pkg::FN_SRDY) begin
      return f[6];
    end else if (code == ofm_pkg::FN_ALM_NC) begin
      return f[7];
    end else begin
      return 1'b0;
    end
  endfunction

  logic [8:0] fvec;
  assign fvec = {1'b0, alarm_closed, servo_ctrl_ready, alarm_detected, brake_release,
                 ovwr, spd_lim, inpos_out, ready_out};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      func_out <= 21'h000000;
    end else if (ce) begin
      for (int i = 0; i < ofm_pkg::NUM_OUT; i++) begin
        func_out[i] <= loading ? 1'b0 : pick(active_code[i], fvec);
      end
    end
  end
  assign general_output = func_out[4:0];
  assign comm_output = func_out[20:5];

  ////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky rising-edge events, write one to clear, set wins.
  logic [3:0] ev_now;
  logic [3:0] ev_prev;
  logic [3:0] ev_rise;
  logic [3:0] w1c;
  assign ev_now = {ovwr, spd_lim, inpos_out, alarm_detected};
  assign ev_rise = ev_now & ~ev_prev;
  assign w1c = (apb_wr && pready && paddr == ofm_pkg::A_IRQ_ST) ? pwdata[3:0] : 4'h0;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ev_prev <= 4'h0;
      irq_status <= 4'h0;
    end else if (ce) begin
      ev_prev <= ev_now;
      irq_status <= (irq_status & ~w1c) | ev_rise;
    end
  end
  assign irq = |(irq_status & irq_mask);
endmodule

// [pkg/ofm_pkg.sv]
// Package of constants and types for the output terminal function mux.
package ofm_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int NUM_OUT = 21;
  localparam int NUM_PHYS = 5;
  localparam int CODE_W = 8;
  localparam int SPD_W = 16;
  localparam int HOLD_W = 16;

  // Function codes.
  localparam logic [7:0] FN_NONE = 8'h00;
  localparam logic [7:0] FN_RDY = 8'h01;
  localparam logic [7:0] FN_INPOS = 8'h02;
  localparam logic [7:0] FN_SPDLIM = 8'h0B;
  localparam logic [7:0] FN_OVWR = 8'h0D;
  localparam logic [7:0] FN_BRAKE = 8'h0E;
  localparam logic [7:0] FN_ALM_NO = 8'h10;
  localparam logic [7:0] FN_SRDY = 8'h1C;
  localparam logic [7:0] FN_ALM_NC = 8'h4C;

  // Power-up assignment defaults.
  localparam logic [7:0] DEF_OUT1 = 8'h01;
  localparam logic [7:0] DEF_OUT2 = 8'h02;
  localparam logic [7:0] DEF_OUT3 = 8'h4C;
  localparam logic [7:0] DEF_OTHER = 8'h00;

  // Byte addresses of the APB registers.
  localparam logic [11:0] A_SEL_BASE = 12'h000;
  localparam logic [11:0] A_SEL_LAST = 12'h050;
  localparam logic [11:0] A_CTRL = 12'h080;
  localparam logic [11:0] A_MAXPS = 12'h084;
  localparam logic [11:0] A_MAXTQ = 12'h088;
  localparam logic [11:0] A_HOLD = 12'h08C;
  localparam logic [11:0] A_OUTS = 12'h090;
  localparam logic [11:0] A_IRQ_ST = 12'h094;
  localparam logic [11:0] A_IRQ_MASK = 12'h098;
  localparam logic [11:0] A_STEP0 = 12'h0A0;
  localparam logic [11:0] A_STEP7 = 12'h0BC;

  // Control register fields, and reset defaults of the speed and hold registers.
  localparam int CTRL_INPOS_FMT = 0;
  localparam int CTRL_TQ_SEL = 1;
  localparam logic [15:0] DEF_SPEED = 16'h1388;
  localparam logic [15:0] DEF_HOLD_MS = 16'h0064;

  // Interrupt status bits.
  localparam int IRQ_W = 4;
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_INPOS = 1;
  localparam int IRQ_SPDLIM = 2;
  localparam int IRQ_OVWR = 3;

  // Timing: one-shot width and one millisecond tick.
  localparam int PULSE_NS = 1000;
  localparam int PULSE_CYC = (PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int MS_CYC = CLK_HZ / 1000;

  typedef enum logic [3:0] {
    OFM_ST_IDLE = 4'b0001,
    OFM_ST_RUN = 4'b0010,
    OFM_ST_HOLD = 4'b0100,
    OFM_ST_OFF = 4'b1000
  } ofm_brake_e;

  typedef enum logic [2:0] {
    OFM_MODE_POS = 3'b001,
    OFM_MODE_SPD = 3'b010,
    OFM_MODE_TRQ = 3'b100
  } ofm_mode_e;
endpackage

// [pkg/ofm_sel_if.sv]
// Interface carrying selection-table access between top and memory.
`timescale 1ns/100ps
interface ofm_sel_if;
  logic we;
  logic [4:0] waddr;
  logic [7:0] wdata;
  logic [4:0] raddr;
  logic [7:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// [test/ofm_checker.sv]
// Assertions on the ports of the output terminal function mux.
`timescale 1ns/100ps
module ofm_checker (
  // Clock, reset and enable.
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // Drive status.
  input wire logic servo_on_input,
  input wire logic forced_stop_input,
  input wire logic coast_input,
  input wire logic alarm_detected,
  input wire logic servo_ctrl_ready,
  input wire logic overtravel,
  input wire logic dev_clear,
  input wire logic positioning_done,
  input wire logic [2:0] control_mode,
  // Outputs.
  input wire logic [4:0] general_output,
  input wire logic brake_release
);
  logic [4:0] boot;
  logic fmt;
  logic loaded;
  logic rc;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  assign loaded = boot == 5'h1F;
  assign rc = servo_on_input && forced_stop_input && !coast_input && !alarm_detected
    && servo_ctrl_ready;

  // Counts enabled cycles after reset to skip the assignment load.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      boot <= 5'h00;
    end else if (ce && !loaded) begin
      boot <= boot + 5'h01;
    end
  end

  // Tracks the in-position output format written by software.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fmt <= 1'b0;
    end else if (psel && penable && pready && pwrite && paddr == ofm_pkg::A_CTRL) begin
      fmt <= pwdata[ofm_pkg::CTRL_INPOS_FMT];
    end
  end

  property p_boot_quiet;
    boot < 5'h14 |-> general_output == 5'h00;
  endproperty
  a_boot_quiet: assert property (p_boot_quiet) else $error("outputs active during load");
  property p_alm_nc;
    loaded |=> general_output[2] == !$past(alarm_detected);
  endproperty
  a_alm_nc: assert property (p_alm_nc) else $error("closed alarm contact wrong");
  property p_rdy_cond;
    loaded && $rose(general_output[0]) |-> $past(rc) || $past(rc, 2);
  endproperty
  a_rdy_cond: assert property (p_rdy_cond) else $error("ready without conditions");
  property p_rdy_alarm;
    loaded && alarm_detected |-> ##2 !general_output[0];
  endproperty
  a_rdy_alarm: assert property (p_rdy_alarm) else $error("ready held in alarm");
  property p_brake;
    loaded && !servo_on_input |=> !brake_release;
  endproperty
  a_brake: assert property (p_brake) else $error("brake released with servo off");
  property p_brake_rdy;
    loaded && $fell(general_output[0]) |-> !brake_release;
  endproperty
  a_brake_rdy: assert property (p_brake_rdy) else $error("ready fell before brake");
  property p_inpos_pos;
    loaded && !fmt && control_mode == ofm_pkg::OFM_MODE_POS |=> general_output[1] ==
      $past((positioning_done || overtravel || dev_clear) && !alarm_detected);
  endproperty
  a_inpos_pos: assert property (p_inpos_pos) else $error("in-position level wrong");
  property p_inpos_ns;
    loaded && !fmt && control_mode != ofm_pkg::OFM_MODE_POS |=> general_output[1];
  endproperty
  a_inpos_ns: assert property (p_inpos_ns) else $error("in-position off in speed mode");

  c_inpos: cover property (loaded && $rose(general_output[1]));
  c_brake: cover property (loaded && $fell(brake_release));
  c_alarm: cover property (loaded && $fell(general_output[2]));
endmodule

// [test/ofm_host.sv]
// Host controller model that watches the drive terminals and times in-position pulses.
`timescale 1ns/100ps
module ofm_host (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Drive terminals.
  input wire logic [4:0] general_output,
  // Width of the last in-position pulse in clock cycles.
  output logic [15:0] inpos_width
);
  logic [15:0] run;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      run <= 16'h0000;
      inpos_width <= 16'h0000;
    end else if (general_output[1]) begin
      run <= run + 16'h0001;
    end else begin
      if (run != 16'h0000) begin
        inpos_width <= run;
      end
      run <= 16'h0000;
    end
  end
endmodule

// [test/tb_output_terminal_function_mux.sv]
// Self-checking bench for the output terminal function mux.
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) bad(); end
module tb_output_terminal_function_mux;
  logic mclk, rst, ce, psel, penable, pwrite, pready, pslverr, brake_release, irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic servo_on_input, forced_stop_input, coast_input, alarm_detected, servo_ctrl_ready;
  logic overtravel, dev_clear, positioning_done, pulse_operation, teach_written, teach_entering;
  logic multistep_speed_sel_0, multistep_speed_sel_1, multistep_speed_sel_2;
  logic [2:0] control_mode;
  logic [15:0] motor_speed, comm_output, inpos_width;
  logic [4:0] general_output;
  int failures, checks_done;

  ofm_top i_dut (.mclk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .servo_on_input, .forced_stop_input, .coast_input, .alarm_detected,
    .servo_ctrl_ready, .overtravel, .dev_clear, .positioning_done, .pulse_operation,
    .control_mode, .motor_speed, .multistep_speed_sel_0, .multistep_speed_sel_1,
    .multistep_speed_sel_2, .teach_written, .teach_entering, .general_output, .comm_output,
    .brake_release, .irq);
  ofm_host i_host (.mclk, .rst, .general_output, .inpos_width);

  always #5 mclk = !mclk;

  ////////////////////////////////////////////////////////////////////////////////
  task bad();
    failures++;
    $display("BAD %0t value mismatch", $time);
  endtask
  task end_of_test();
    $display("failures %0d checks %0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task w(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task apb(input logic wrt, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wrt;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) bad();
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(q, x)
    `CHK(e, 1'b0)
  endtask
  task cond(input logic [4:0] v);
    @(posedge mclk);
    servo_on_input <= v[0];
    forced_stop_input <= v[1];
    coast_input <= !v[2];
    alarm_detected <= !v[3];
    servo_ctrl_ready <= v[4];
  endtask
  task spd(input logic [15:0] s, input logic x);
    @(posedge mclk);
    motor_speed <= s;
    w(3);
    `CHK(general_output[3], x)
  endtask
  task do_reset();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    w(30);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task t_regs();
    rd(12'h000, 32'h0000_0001);
    rd(12'h008, 32'h0000_004C);
    rd(12'h010, 32'h0000_0000);
    rd(ofm_pkg::A_MAXTQ, {16'h0000, ofm_pkg::DEF_SPEED});
    rd(ofm_pkg::A_HOLD, {16'h0000, ofm_pkg::DEF_HOLD_MS});
    rd(ofm_pkg::A_CTRL, 32'h0000_0000);
    apb(1'b0, 12'h0C0, 32'h0000_0000);
    `CHK({e, q}, 33'h1_0000_0000)
    apb(1'b1, ofm_pkg::A_HOLD, 32'h0000_0000);
  endtask
  task t_ready();
    for (int i = 0; i < 5; i++) begin
      cond(5'h1F);
      w(6);
      `CHK({general_output[0], brake_release}, 2'b11)
      cond(5'h1F ^ (5'h01 << i));
      w(6);
      `CHK({general_output[0], brake_release}, 2'b00)
      `CHK(general_output[2], i != 3)
    end
  endtask
  task t_irq();
    cond(5'h1F);
    apb(1'b1, ofm_pkg::A_IRQ_ST, 32'h0000_000F);
    apb(1'b1, ofm_pkg::A_IRQ_MASK, 32'h0000_0001);
    `CHK(irq, 1'b0)
    cond(5'h17);
    w(3);
    `CHK(irq, 1'b1)
    apb(1'b1, ofm_pkg::A_IRQ_MASK, 32'h0000_0000);
    w(1);
    `CHK(irq, 1'b0)
    apb(1'b1, ofm_pkg::A_IRQ_MASK, 32'h0000_0001);
    cond(5'h1F);
    apb(1'b1, ofm_pkg::A_IRQ_ST, 32'h0000_0001);
    w(1);
    `CHK(irq, 1'b0)
  endtask
  task t_inpos();
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      {positioning_done, overtravel, dev_clear} <= (i == 0) ? 3'h0 : 3'h4 >> (i - 1);
      w(3);
      `CHK(general_output[1], i != 0)
    end
    cond(5'h1E);
    w(3);
    `CHK(general_output[1], 1'b1)
    cond(5'h17);
    w(3);
    `CHK(general_output[1], 1'b0)
    cond(5'h1F);
    @(posedge mclk);
    dev_clear <= 1'b0;
    control_mode <= ofm_pkg::OFM_MODE_SPD;
    w(3);
    `CHK(general_output[1], 1'b1)
    @(posedge mclk);
    control_mode <= ofm_pkg::OFM_MODE_TRQ;
    w(3);
    `CHK(general_output[1], 1'b1)
    @(posedge mclk);
    control_mode <= ofm_pkg::OFM_MODE_POS;
    // Lets the pulse of the earlier in-position rise run out first.
    w(ofm_pkg::PULSE_CYC);
    apb(1'b1, ofm_pkg::A_CTRL, 32'h0000_0001);
    @(posedge mclk);
    positioning_done <= 1'b1;
    w(ofm_pkg::PULSE_CYC + 10);
    `CHK(general_output[1], 1'b0)
    `CHK(inpos_width, 16'(ofm_pkg::PULSE_CYC))
    @(posedge mclk);
    positioning_done <= 1'b0;
    apb(1'b1, ofm_pkg::A_CTRL, 32'h0000_0000);
  endtask
  task t_limit();
    apb(1'b1, 12'h00C, {24'h0, ofm_pkg::FN_SPDLIM});
    apb(1'b1, 12'h010, {24'h0, ofm_pkg::FN_OVWR});
    apb(1'b1, 12'h014, {24'h0, ofm_pkg::FN_ALM_NO});
    spd(16'hFFFF, 1'b0);
    do_reset();
    apb(1'b1, ofm_pkg::A_MAXPS, 32'h0000_0064);
    spd(16'h0064, 1'b1);
    spd(16'h0063, 1'b0);
    @(posedge mclk);
    pulse_operation <= 1'b1;
    spd(16'h0064, 1'b0);
    @(posedge mclk);
    pulse_operation <= 1'b0;
    control_mode <= ofm_pkg::OFM_MODE_SPD;
    spd(16'h0064, 1'b1);
    @(posedge mclk);
    control_mode <= ofm_pkg::OFM_MODE_TRQ;
    apb(1'b1, ofm_pkg::A_MAXTQ, 32'h0000_00C8);
    spd(16'h0096, 1'b0);
    spd(16'h00C8, 1'b1);
    apb(1'b1, ofm_pkg::A_STEP0 + 12'h00C, 32'h0000_0032);
    apb(1'b1, ofm_pkg::A_STEP0, 32'h0000_03E8);
    apb(1'b1, ofm_pkg::A_CTRL, 32'h0000_0002);
    @(posedge mclk);
    {multistep_speed_sel_1, multistep_speed_sel_0} <= 2'b11;
    spd(16'h003C, 1'b1);
    @(posedge mclk);
    {multistep_speed_sel_1, multistep_speed_sel_0} <= 2'b00;
    spd(16'h003C, 1'b0);
    cond(5'h17);
    w(3);
    `CHK(comm_output, 16'h0001)
    cond(5'h1F);
    w(3);
    `CHK(comm_output, 16'h0000)
    @(posedge mclk);
    teach_entering <= 1'b1;
    teach_written <= 1'b1;
    @(posedge mclk);
    teach_written <= 1'b0;
    w(3);
    `CHK(general_output[4], 1'b1)
    w(10);
    `CHK(general_output[4], 1'b1)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {mclk, ce, psel, penable, pwrite, paddr, pwdata} = {1'b0, 1'b1, 47'h0};
    {servo_on_input, forced_stop_input, coast_input, alarm_detected, servo_ctrl_ready} = 5'h00;
    {overtravel, dev_clear, positioning_done, pulse_operation, teach_written} = 5'h00;
    {teach_entering, multistep_speed_sel_0, multistep_speed_sel_1, multistep_speed_sel_2} = 4'h0;
    control_mode = ofm_pkg::OFM_MODE_POS;
    motor_speed = 16'h0000;
    failures = 0;
    checks_done = 0;
    rst = 1'b1;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    w(30);
    t_regs();
    t_ready();
    t_irq();
    t_inpos();
    t_limit();
    end_of_test();
  end

  initial begin
    #300000;
    bad();
    end_of_test();
  end
endmodule

bind ofm_top ofm_checker i_chk (.mclk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .servo_on_input, .forced_stop_input, .coast_input, .alarm_detected,
  .servo_ctrl_ready, .overtravel, .dev_clear, .positioning_done, .control_mode,
  .general_output, .brake_release);
